// ---- include/ssac_pkg.sv ----
// Package with widths, burst orders and reset values for the SRAM address and write front end.
package ssac_pkg;
  localparam int ADDR_W = 19;
  localparam int DEPTH = 524288;
  localparam int LANES = 2;
  localparam int BURST_W = 2;
  localparam logic [18:0] ADDR_RST = 19'h00000;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] LANE_RST = 2'h0;
  localparam logic [0:0] STRAP_INTERLEAVED = 1'h1;

  typedef enum logic {
    SSAC_LINEAR,
    SSAC_INTERLEAVED
  } ssac_order_t;
endpackage : ssac_pkg

// ---- rtl/ssac_burst_counter.sv ----
// Two-bit burst counter with linear or interleaved sequence.
`timescale 1ns/100ps
`default_nettype none
module ssac_burst_counter
  import ssac_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control.
  input wire logic load_i,
  input wire logic [BURST_W-1:0] start_i,
  input wire logic step_i,
  input wire ssac_order_t order_i,
  // Result.
  output logic [BURST_W-1:0] offset_o
);
  logic [BURST_W-1:0] start_q, start_d;
  logic [BURST_W-1:0] count_q, count_d;
  logic [BURST_W-1:0] offset_q, offset_d;

  always_comb
  begin
    start_d = start_q;
    count_d = count_q;
    if (load_i)
    begin
      start_d = start_i;
      count_d = BURST_RST;
    end
    else if (step_i)
    begin
      count_d = count_q + STEP_ONE;
    end
    if (order_i == SSAC_LINEAR)
    begin
      offset_d = start_d + count_d;
    end
    else
    begin
      offset_d = start_d ^ count_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      start_q <= BURST_RST;
      count_q <= BURST_RST;
      offset_q <= BURST_RST;
    end
    else
    begin
      start_q <= start_d;
      count_q <= count_d;
      offset_q <= offset_d;
    end
  end

  assign offset_o = offset_q;
endmodule : ssac_burst_counter
`default_nettype wire

// ---- rtl/ssac_front_end.sv ----
// Address capture, burst sequencing and byte lane write decode of a synchronous SRAM.
// Notes on behaviour
// - The 19-bit address selects exactly one of the 512K word locations.
// - The address is captured only when a strobe is low and all chip selects are active.
// - A captured address loads its two low bits into the two-bit burst counter.
// - A low order strap gives linear bursts, a high or floating strap interleaved ones.
// - A lane is written when its select is low and the lane write qualifier is low.
// - A low global write writes every lane regardless of selects and qualifier.
// - With both strobes low only the processor strobe is acted on.
// - A low step input during a burst advances the counter on each rising edge.
`timescale 1ns/100ps
`default_nettype none
module ssac_front_end
  import ssac_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Address and strobes from the host.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic processor_addr_strobe_n_i,
  input wire logic controller_addr_strobe_n_i,
  input wire logic burst_step_n_i,
  // Chip selects.
  input wire logic chip_select_primary_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  // Write controls.
  input wire logic lane_a_write_select_n_i,
  input wire logic lane_b_write_select_n_i,
  input wire logic lane_write_qualifier_n_i,
  input wire logic all_lanes_write_n_i,
  // Burst order strap.
  input wire logic order_strap_i,
  // Array side.
  output logic [ADDR_W-1:0] word_addr_o,
  output logic [LANES-1:0] lane_write_o,
  output logic selected_o,
  output logic processor_cycle_o
);
  // Pins cross from outside the clock domain through two flops.
  localparam int NSYNC = ADDR_W + 11;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  assign pin_raw = {addr_i, processor_addr_strobe_n_i, controller_addr_strobe_n_i,
                    burst_step_n_i, chip_select_primary_n_i, chip_select_second_i,
                    chip_select_third_n_i, lane_a_write_select_n_i, lane_b_write_select_n_i,
                    lane_write_qualifier_n_i, all_lanes_write_n_i, order_strap_i};

  // Every pin lags by the same two cycles, so the decisions below see one consistent
  // snapshot of the bus.
  always_ff @(posedge clk_i)
  begin
    sync1_q <= pin_raw;
    sync2_q <= sync1_q;
  end

  logic [ADDR_W-1:0] s_addr;
  logic s_psn, s_csn, s_stepn, s_ce1n, s_ce2, s_ce3n, s_lan, s_lbn, s_qn, s_gwn, s_strap;
  assign s_addr = sync2_q[NSYNC-1 -: ADDR_W];
  assign s_psn = sync2_q[10];
  assign s_csn = sync2_q[9];
  assign s_stepn = sync2_q[8];
  assign s_ce1n = sync2_q[7];
  assign s_ce2 = sync2_q[6];
  assign s_ce3n = sync2_q[5];
  assign s_lan = sync2_q[4];
  assign s_lbn = sync2_q[3];
  assign s_qn = sync2_q[2];
  assign s_gwn = sync2_q[1];
  assign s_strap = sync2_q[0];

  // The device answers only when all three chip selects are active at once.
  function automatic logic chip_active(input logic ce1n, input logic ce2, input logic ce3n);
    chip_active = !ce1n && ce2 && !ce3n;
  endfunction : chip_active

  logic sel_now, capture, by_processor;
  ssac_order_t order;
  logic [BURST_W-1:0] burst_off;

  always_comb
  begin
    sel_now = chip_active(s_ce1n, s_ce2, s_ce3n);
    capture = sel_now && (!s_psn || !s_csn);
    by_processor = sel_now && !s_psn;
    // The strap is read every cycle and is taken to be static in operation.
    order = (s_strap == STRAP_INTERLEAVED[0]) ? SSAC_INTERLEAVED : SSAC_LINEAR;
  end

  logic [ADDR_W-1:0] base_q, base_d;
  logic burst_q, burst_d;
  logic [ADDR_W-1:0] word_addr_q, word_addr_d;
  logic [LANES-1:0] lane_write_q, lane_write_d;
  logic selected_q, selected_d;
  logic processor_q, processor_d;
  logic step;
  logic [LANES-1:0] sel_n;

  // A step on the capture edge is dropped, so a burst always begins at its start value.
  assign step = burst_q && !capture && !s_stepn;
  assign sel_n = {s_lbn, s_lan};

  // The counter sees the same capture decision as the address register.
  ssac_burst_counter u_burst
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(capture),
    .start_i(s_addr[BURST_W-1:0]),
    .step_i(step),
    .order_i(order),
    .offset_o(burst_off)
  );

  always_comb
  begin
    base_d = base_q;
    burst_d = burst_q;
    selected_d = selected_q;
    processor_d = processor_q;
    if (capture)
    begin
      base_d = s_addr;
      burst_d = 1'b1;
      selected_d = 1'b1;
      processor_d = by_processor;
    end
    // A strobe while deselected closes the burst, so later steps cannot move the counter.
    else if (!s_psn || !s_csn)
    begin
      burst_d = 1'b0;
      selected_d = 1'b0;
    end
    // The captured upper part sits above the live burst offset.
    word_addr_d = {base_q[ADDR_W-1:BURST_W], burst_off};
    // Global write overrides the lane selects; a lane write also needs the qualifier.
    for (int i = 0; i < LANES; i++)
    begin
      lane_write_d[i] = !s_gwn || (!s_qn && !sel_n[i]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      base_q <= ADDR_RST;
      burst_q <= 1'b0;
      word_addr_q <= ADDR_RST;
      lane_write_q <= LANE_RST;
      selected_q <= 1'b0;
      processor_q <= 1'b0;
    end
    else
    begin
      base_q <= base_d;
      burst_q <= burst_d;
      word_addr_q <= word_addr_d;
      lane_write_q <= lane_write_d;
      selected_q <= selected_d;
      processor_q <= processor_d;
    end
  end

  assign word_addr_o = word_addr_q;
  assign lane_write_o = lane_write_q;
  assign selected_o = selected_q;
  assign processor_cycle_o = processor_q;

  // The checks below watch the synchronised pins, two cycles behind the package pins.
  property p_capture;
    @(posedge clk_i) disable iff (!reset_n_i)
      capture |=> base_q == $past(s_addr);
  endproperty
  capture_addr_a: assert property (p_capture) else $error("address not captured");
  no_capture_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!sel_now) |=> $stable(base_q)) else $error("address captured while deselected");
  burst_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    capture |=> ##1 word_addr_q[1:0] == $past(s_addr[1:0], 2))
    else $error("burst start not loaded");
  proc_prio_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (capture && !s_psn) |=> processor_q) else $error("processor strobe not preferred");
  global_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !s_gwn |=> lane_write_q == 2'h3) else $error("global write missed a lane");
  lane_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_gwn && s_qn) |=> lane_write_q == 2'h0) else $error("lane written without qualifier");
  lane_a_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_gwn && !s_qn) |=> lane_write_q[0] == !$past(s_lan)) else $error("lane a decode");
  linear_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (step && order == SSAC_LINEAR && $stable(order)) |=> ##1
      word_addr_q[1:0] == $past(word_addr_q[1:0]) + 2'h1) else $error("linear step wrong");
  addr_upper_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    capture |=> ##1 word_addr_q[ADDR_W-1:2] == $past(s_addr[ADDR_W-1:2], 2))
    else $error("upper address wrong");
  interleave_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (capture && order == SSAC_INTERLEAVED) ##1 (step && order == SSAC_INTERLEAVED) |=> ##1
      word_addr_q[1:0] == ($past(s_addr[1:0], 3) ^ 2'h1)) else $error("interleave wrong");
  lane_b_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_gwn && !s_qn) |=> lane_write_q[1] == !$past(s_lbn))
    else $error("lane b decode");
  ctrl_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (capture && s_psn) |=> !processor_q)
    else $error("controller capture flagged as processor");
  select_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    capture |=> selected_q) else $error("capture not flagged");
  deselect_end_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!sel_now && (!s_psn || !s_csn)) |=> (!selected_q && !burst_q))
    else $error("deselected strobe kept the burst");
  idle_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!burst_q && !capture && !s_stepn && $stable(order)) |=> $stable(burst_off))
    else $error("counter moved outside a burst");
  step_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!step && !capture && $stable(order)) |=> $stable(burst_off))
    else $error("counter moved without a step");

  // Covers for controller-only and dual-strobe captures, a long burst, a lane write and an interleaved start.

  cov_ctrl_c: cover property (@(posedge clk_i) capture && !s_csn && s_psn);
  cov_both_c: cover property (@(posedge clk_i) capture && !s_csn && !s_psn);
  cov_burst_c: cover property (@(posedge clk_i) step [*3]);
  cov_lane_c: cover property (@(posedge clk_i) s_gwn && !s_qn && !s_lbn && s_lan);
  cov_inter_c: cover property (@(posedge clk_i)
    (capture && order == SSAC_INTERLEAVED) ##1 (step && order == SSAC_INTERLEAVED));
endmodule : ssac_front_end
`default_nettype wire

// ---- verification/ssac_host.sv ----
// Host model that drives the pins of the SRAM address and write front end.
`timescale 1ns/100ps
`default_nettype none
module ssac_host
  import ssac_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Pins as vectors: strobes {processor, controller}, selects {primary, second, third}.
  output logic [ADDR_W-1:0] addr_o,
  output logic [1:0] strobe_n_o,
  output logic step_n_o,
  output logic [2:0] sel_o,
  // Writes {all lanes, qualifier, lane a, lane b}, all active low.
  output logic [3:0] wr_o,
  output logic strap_o
);
  initial
  begin
    addr_o = '0;
    strobe_n_o = 2'h3;
    step_n_o = 1'h1;
    sel_o = 3'h2;
    wr_o = 4'hF;
    strap_o = 1'h1;
  end

  task automatic cap(input logic [18:0] a, input logic [1:0] s, input logic [2:0] c);
    @(posedge clk_i);
    addr_o <= a;
    strobe_n_o <= s;
    sel_o <= c;
    @(posedge clk_i);
    // The address is no longer valid, so show its inverse.
    addr_o <= ~a;
    strobe_n_o <= 2'h3;
    sel_o <= 3'h2;
  endtask : cap

  // Starts on the edge at which it is called, so it can follow a capture with no gap.
  task automatic step(input int k);
    step_n_o <= 1'h0;
    repeat (k) @(posedge clk_i);
    step_n_o <= 1'h1;
  endtask : step

  task automatic wr(input logic [3:0] w);
    @(posedge clk_i);
    wr_o <= w;
    @(posedge clk_i);
    wr_o <= 4'hF;
  endtask : wr

  // Only called while reset is held, so the strap stays static in operation.
  task automatic order(input logic o);
    strap_o <= o;
  endtask : order
endmodule : ssac_host
`default_nettype wire

// ---- verification/tb_sync_sram_addr_write_control.sv ----
// Self-checking testbench of the SRAM address and write front end.
`timescale 1ns/100ps
`default_nettype none
module tb_sync_sram_addr_write_control
  import ssac_pkg::*;
;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [18:0] addr;
  logic [1:0] strobe_n;
  logic step_n;
  logic [2:0] sel;
  logic [3:0] wr;
  logic strap;
  logic [18:0] word_addr;
  logic [1:0] lane_write;
  logic selected;
  logic proc;
  int errors = 0;
  int n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  ssac_host host (.clk_i(clk_i), .addr_o(addr), .strobe_n_o(strobe_n), .step_n_o(step_n),
    .sel_o(sel), .wr_o(wr), .strap_o(strap));

  ssac_front_end dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr),
    .processor_addr_strobe_n_i(strobe_n[1]), .controller_addr_strobe_n_i(strobe_n[0]),
    .burst_step_n_i(step_n), .chip_select_primary_n_i(sel[2]),
    .chip_select_second_i(sel[1]), .chip_select_third_n_i(sel[0]),
    .lane_a_write_select_n_i(wr[1]), .lane_b_write_select_n_i(wr[0]),
    .lane_write_qualifier_n_i(wr[2]), .all_lanes_write_n_i(wr[3]), .order_strap_i(strap),
    .word_addr_o(word_addr), .lane_write_o(lane_write), .selected_o(selected),
    .processor_cycle_o(proc));

  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic rst(input int n, input logic o);
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    host.order(o);
    repeat (n) @(posedge clk_i);
    reset_n_i <= 1'h1;
    wt(1);
    chk("reset addr", 19'h00000, word_addr);
    chk("reset flags", 19'h00000, {15'h0000, lane_write, selected, proc});
  endtask : rst

  task automatic t_cap;
    logic [1:0] s[3] = '{2'h1, 2'h0, 2'h2};
    for (int i = 0; i < 3; i++)
    begin
      host.cap(19'h7FFFC + 19'(i), s[i], 3'h2);
      wt(6);
      chk("capture addr", 19'h7FFFC + 19'(i), word_addr);
      chk("capture flags", {17'h00000, 1'h1, ~s[i][1]}, {17'h00000, selected, proc});
    end
    $display("test capture done");
  endtask : t_cap

  task automatic t_refuse;
    logic [2:0] c[3] = '{3'h6, 3'h0, 3'h3};
    host.cap(19'h12345, 2'h2, 3'h2);
    for (int i = 0; i < 3; i++)
    begin
      host.cap(19'h6A5A0, 2'h1, c[i]);
      wt(6);
      chk("refused addr", 19'h12345, word_addr);
      chk("refused select", 19'h00000, {18'h00000, selected});
    end
    // No burst is open now, so steps must leave the address alone.
    @(posedge clk_i);
    host.step(2);
    wt(6);
    chk("refused step", 19'h12345, word_addr);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_burst;
    logic [1:0] x;
    for (int o = 0; o < 2; o++)
    begin
      rst(3, o[0]);
      for (int s = 0; s < 4; s++)
      begin
        for (int k = 1; k < 4; k++)
        begin
          host.cap({17'h0ABCD, s[1:0]}, 2'h1, 3'h2);
          host.step(k);
          wt(6);
          x = o[0] ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0]);
          chk("burst addr", {17'h0ABCD, x}, word_addr);
        end
      end
    end
    $display("test burst done");
  endtask : t_burst

  task automatic t_write;
    logic [3:0] w[6] = '{4'h7, 4'h0, 4'h9, 4'hA, 4'h8, 4'hC};
    logic [1:0] e[6] = '{2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] seen;
    int cnt;
    host.cap(19'h00F00, 2'h1, 3'h2);
    for (int i = 0; i < 6; i++)
    begin
      wt(4);
      host.wr(w[i]);
      seen = 2'h0;
      cnt = 0;
      for (int j = 0; j < 8; j++)
      begin
        wt(1);
        seen = seen | lane_write;
        cnt += int'(lane_write != 2'h0);
      end
      chk("lane write", {17'h00000, e[i]}, {17'h00000, seen});
      chk("write cycles", 19'(e[i] != 2'h0), 19'(cnt));
    end
    $display("test write done");
  endtask : t_write

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  initial
  begin
    rst(20, 1'h1);
    t_cap();
    t_refuse();
    t_write();
    t_burst();
    conclude();
  end
endmodule : tb_sync_sram_addr_write_control
`default_nettype wire
